// ===== shared/rcr_pkg.sv
// package of register map constants and types for the channel and range register bank
package rcr_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  // printed offsets are register indices; byte address is four times the index
  localparam logic [2:0]  IDX_CHANNEL  = 3'h3;
  localparam logic [2:0]  IDX_RANGE_A1 = 3'h4;
  localparam logic [2:0]  IDX_RANGE_A2 = 3'h5;
  localparam logic [2:0]  IDX_RANGE_B1 = 3'h6;
  localparam logic [2:0]  IDX_RANGE_B2 = 3'h7;
  localparam logic [11:0] ADDR_CHANNEL  = 12'h00C;
  localparam logic [11:0] ADDR_RANGE_A1 = 12'h010;
  localparam logic [11:0] ADDR_RANGE_A2 = 12'h014;
  localparam logic [11:0] ADDR_RANGE_B1 = 12'h018;
  localparam logic [11:0] ADDR_RANGE_B2 = 12'h01C;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int ADDR_FIELD_LSB = 9;
  localparam int ADDR_FIELD_MSB = 15;
  localparam int RSVD_BIT       = 8;
  localparam int SEL_B_LSB      = 4;
  localparam int SEL_A_LSB      = 0;
  localparam int CH_W           = 4;
  localparam int RANGE_W        = 2;
  localparam logic [15:0] CHANNEL_RESET = 16'h0000;
  localparam logic [15:0] RANGE_RESET   = 16'h00FF;
  localparam logic [6:0]  ADDR_FIELD_RESET = 7'h00;

  // ****************************************************************
  // channel codes and test patterns
  // ****************************************************************
  localparam logic [3:0]  CH_LAST_INPUT  = 4'h7;
  localparam logic [3:0]  CH_SUPPLY_MON  = 4'h8;
  localparam logic [3:0]  CH_REG_MON     = 4'h9;
  localparam logic [3:0]  CH_SELF_TEST   = 4'hB;
  localparam logic [15:0] TEST_PATTERN_A = 16'hAAAA;
  localparam logic [15:0] TEST_PATTERN_B = 16'h5555;

  // decoded source kinds, one-hot
  typedef enum logic [3:0] {
    RCR_SRC_NONE   = 4'b0001,
    RCR_SRC_INPUT  = 4'b0010,
    RCR_SRC_MON    = 4'b0100,
    RCR_SRC_TEST   = 4'b1000
  } rcr_src_t;

  // decoded input range, one-hot
  typedef enum logic [2:0] {
    RCR_RNG_10V  = 3'b001,
    RCR_RNG_5V   = 3'b010,
    RCR_RNG_2V5  = 3'b100
  } rcr_range_t;

endpackage

// ===== core/rcr_bank.sv
// register bank for the adc channel selects and input ranges, apb slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps

module rcr_bank (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // raw conversion results from the converters
  input  wire logic [15:0] conv_result_a,
  input  wire logic [15:0] conv_result_b,
  // channel selection towards the sequencer
  output logic      [3:0]  adc_a_chan_select,
  output logic      [3:0]  adc_b_chan_select,
  output rcr_pkg::rcr_src_t src_kind_a,
  output rcr_pkg::rcr_src_t src_kind_b,
  // results as presented to the host
  output logic      [15:0] result_a,
  output logic      [15:0] result_b,
  // range selection per input
  output logic      [15:0] range_a_codes,
  output logic      [15:0] range_b_codes,
  output rcr_pkg::rcr_range_t range_in0_a,
  output rcr_pkg::rcr_range_t range_in1_a,
  output rcr_pkg::rcr_range_t range_in2_a,
  output rcr_pkg::rcr_range_t range_in3_a
);

  // ****************************************************************
  // state
  // ****************************************************************
  // every field is a packed vector so the whole state is one packed word
  typedef struct packed {
    // bits 15:9 of the channel register and the four range registers, in index order
    logic [4:0][6:0] addr_field;
    // channel register bits 7:0: adc b select high nibble, adc a select low nibble
    logic [7:0]      chan;
    // range registers a1, a2, b1, b2, bits 7:0 each
    logic [3:0][7:0] range_cfg;
  } rcr_state_t;

  rcr_state_t st;
  rcr_state_t next_st;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // the monitor codes and test code are the only legal codes above 7
  // reserved codes fall to none so they never reach the converter as an input number
  function automatic rcr_pkg::rcr_src_t decode_src(input logic [3:0] code);
    rcr_pkg::rcr_src_t k;
    k = rcr_pkg::RCR_SRC_NONE;
    case (code)
      rcr_pkg::CH_SUPPLY_MON,
      rcr_pkg::CH_REG_MON:   k = rcr_pkg::RCR_SRC_MON;
      rcr_pkg::CH_SELF_TEST: k = rcr_pkg::RCR_SRC_TEST;
      default: begin
        if (code <= rcr_pkg::CH_LAST_INPUT) begin
          k = rcr_pkg::RCR_SRC_INPUT;
        end
      end
    endcase
    return k;
  endfunction

  // 11 aliases 00 so an all-ones reset lands on the widest range
  // the output is one-hot so a downstream gain switch needs no decoder of its own
  function automatic rcr_pkg::rcr_range_t decode_range(input logic [1:0] code);
    rcr_pkg::rcr_range_t r;
    case (code)
      2'h1:    r = rcr_pkg::RCR_RNG_2V5;
      2'h2:    r = rcr_pkg::RCR_RNG_5V;
      default: r = rcr_pkg::RCR_RNG_10V;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // apb access
  // ****************************************************************
  // decode results shared by the write path and the read mux
  logic       access;
  logic       hit;
  logic [2:0] slot;
  logic [2:0] sel_idx;
  logic [15:0] rd_word;

  // the second cycle of a transfer; with pready tied high it is also the last
  assign access = psel && penable;

  // index decode; slot 0 is the channel register, slots 1-4 the range registers
  // an offset that is not word aligned misses, since each register is one whole word
  // channel at index 3
  always_comb begin
    hit     = 1'b0;
    slot    = 3'h0;
    sel_idx = 3'h0;
    if (paddr[1:0] == 2'h0 && paddr[11:5] == 7'h00) begin
      sel_idx = paddr[4:2];
      if (sel_idx >= rcr_pkg::IDX_CHANNEL) begin
        hit  = 1'b1;
        slot = 3'(sel_idx - rcr_pkg::IDX_CHANNEL);
      end
    end
  end

  // read mux; a miss leaves slot at zero, and prdata masks it with hit anyway
  // bit 8 always reads zero, whatever was written to it
  always_comb begin
    rd_word = 16'h0000;
    if (slot == 3'h0) begin
      rd_word = {st.addr_field[0], 1'b0, st.chan};
    end else begin
      rd_word = {st.addr_field[slot], 1'b0, st.range_cfg[2'(slot - 3'h1)]};
    end
  end

  // next state: writes land at the access edge; reads need no state, the mux serves them
  always_comb begin
    next_st = st;
    // only the access phase commits a write, so a setup cycle alone changes nothing
    if (access) begin
      // a refused access leaves every register untouched
      if (hit && pwrite) begin
        // address field held from bits 15:9
        if (pstrb[1]) begin
          next_st.addr_field[slot] = pwdata[rcr_pkg::ADDR_FIELD_MSB:rcr_pkg::ADDR_FIELD_LSB];
        end
        if (pstrb[0]) begin
          if (slot == 3'h0) begin
            next_st.chan = pwdata[7:0];
          end else begin
            next_st.range_cfg[2'(slot - 3'h1)] = pwdata[7:0];
          end
        end
      end
    end
  end

  // register the state
  // asynchronous reset loads constants only, so the bank is defined before any clock
  // channel select resets to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.addr_field <= {5{rcr_pkg::ADDR_FIELD_RESET}};
      st.chan       <= rcr_pkg::CHANNEL_RESET[7:0];
      st.range_cfg  <= {4{rcr_pkg::RANGE_RESET[7:0]}};
    end else begin
      st <= next_st;
    end
  end

  // zero wait state slave; read data follows the address through the access phase
  // limitation: prdata follows paddr and is not held once paddr changes, a master must take it at the edge
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = hit ? {16'h0000, rd_word} : 32'h0000_0000;

  // ****************************************************************
  // channel selection and result path
  // ****************************************************************
  // channel register steers the next conversion
  // low nibble is the adc a select
  // the selects come straight from the register, so software reads back what it steered
  assign adc_a_chan_select = st.chan[rcr_pkg::SEL_A_LSB +: rcr_pkg::CH_W];
  assign adc_b_chan_select = st.chan[rcr_pkg::SEL_B_LSB +: rcr_pkg::CH_W];
  // reserved codes map to no source
  assign src_kind_a = decode_src(adc_a_chan_select);
  assign src_kind_b = decode_src(adc_b_chan_select);

  // the swap sits after the converter, so self test exercises only the result path
  // test pattern substitutes channel a result
  assign result_a = (src_kind_a == rcr_pkg::RCR_SRC_TEST) ? rcr_pkg::TEST_PATTERN_A
                                                          : conv_result_a;
  // test pattern substitutes channel b result
  assign result_b = (src_kind_b == rcr_pkg::RCR_SRC_TEST) ? rcr_pkg::TEST_PATTERN_B
                                                          : conv_result_b;

  // ****************************************************************
  // range outputs
  // ****************************************************************
  // raw codes go out whole so inputs 4-7 and the b side are decoded downstream
  // a pair of registers per adc
  assign range_a_codes = {st.range_cfg[1], st.range_cfg[0]};
  assign range_b_codes = {st.range_cfg[3], st.range_cfg[2]};
  // one decoder per field of range register a1, the same logic for every input
  rcr_pkg::rcr_range_t range_a1_dec [4];

  for (genvar gi = 0; gi < 4; gi++) begin : g_range_dec
    assign range_a1_dec[gi] =
      decode_range(st.range_cfg[0][gi*rcr_pkg::RANGE_W +: rcr_pkg::RANGE_W]);
  end

  // ports are named per input, so the array fans out by hand
  assign range_in0_a = range_a1_dec[0];
  assign range_in1_a = range_a1_dec[1];
  assign range_in2_a = range_a1_dec[2];
  assign range_in3_a = range_a1_dec[3];

endmodule

// ===== dv/rcr_bank_sva.sv
// checker of the channel and range register bank ports
`timescale 1ns/1ps
module rcr_bank_sva (
  // clock, reset and apb
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  // results and selections
  input wire logic [15:0]         conv_result_a,
  input wire logic [15:0]         result_a,
  input wire logic [15:0]         result_b,
  input wire logic [3:0]          adc_a_chan_select,
  input wire logic [3:0]          adc_b_chan_select,
  input wire rcr_pkg::rcr_src_t   src_kind_a,
  input wire logic [15:0]         range_a_codes,
  input wire rcr_pkg::rcr_range_t range_in0_a
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] wr_cha;
  // low nibble of write data, kept apart so $past sees a plain signal
  assign wr_cha = pwdata[3:0];
  a_pattern_a: assert property (adc_a_chan_select == 4'hB |-> result_a == 16'hAAAA)
    else $error("channel a test pattern missing");
  a_pass_a: assert property (adc_a_chan_select != 4'hB |-> result_a == conv_result_a)
    else $error("channel a result not passed through");
  a_pattern_b: assert property (adc_b_chan_select == 4'hB |-> result_b == 16'h5555)
    else $error("channel b test pattern missing");
  a_src_input: assert property (adc_a_chan_select <= 4'h7 |->
    src_kind_a == rcr_pkg::RCR_SRC_INPUT)
    else $error("input code not decoded");
  a_src_mon: assert property (adc_a_chan_select inside {4'h8, 4'h9} |->
    src_kind_a == rcr_pkg::RCR_SRC_MON)
    else $error("monitor code not decoded");
  a_src_none: assert property (adc_a_chan_select inside {4'hA, 4'hC} |->
    src_kind_a == rcr_pkg::RCR_SRC_NONE)
    else $error("reserved code not refused");
  a_range_half: assert property (range_a_codes[1:0] == 2'h1 |->
    range_in0_a == rcr_pkg::RCR_RNG_2V5)
    else $error("range code one not decoded");
  // only lane 0 carries the selects, so a write with it to the channel register must show its low nibble on the adc a select a cycle later
  a_chan_write: assert property (psel && penable && pwrite && pstrb[0] &&
    paddr == 12'h00C |=> adc_a_chan_select == $past(wr_cha))
    else $error("channel write not stored");
  a_unmapped: assert property (psel && penable && paddr == 12'h008 |->
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_rsvd_read: assert property (psel && penable && !pwrite |->
    prdata[8] == 1'b0 && prdata[31:16] == 16'h0000)
    else $error("reserved read bits not zero");
endmodule
bind rcr_bank rcr_bank_sva i_rcr_bank_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pslverr, .conv_result_a, .result_a, .result_b,
  .adc_a_chan_select, .adc_b_chan_select, .src_kind_a, .range_a_codes, .range_in0_a);

// ===== dv/rcr_bank_tb.sv
// self-checking bench of the channel and range register bank
`timescale 1ns/1ps
module rcr_bank_tb;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] rd; logic er;} rcr_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er_q;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [3:0]  pstrb = 4'hF, adc_a_chan_select, adc_b_chan_select;
  logic [15:0] result_a, result_b, range_a_codes, range_b_codes;
  rcr_pkg::rcr_src_t   src_kind_a, src_kind_b;
  rcr_pkg::rcr_range_t range_in0_a, range_in1_a, range_in2_a, range_in3_a;
  int bad_count = 0, compares = 0;
  rcr_row_t rows [8] = '{
    '{12'h00C, 32'hFFFFFF1B, 32'h0000FE1B, 1'b0}, '{12'h010, 32'h000000E4, 32'h000000E4, 1'b0},
    '{12'h014, 32'h00000A5A, 32'h00000A5A, 1'b0}, '{12'h018, 32'h00000155, 32'h00000055, 1'b0},
    '{12'h01C, 32'h000004AA, 32'h000004AA, 1'b0}, '{12'h008, 32'h0000FFFF, 32'h0, 1'b1},
    '{12'h00E, 32'h0000FFFF, 32'h0, 1'b1}, '{12'h020, 32'h0000FFFF, 32'h0, 1'b1}};
  rcr_bank i_rcr_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .conv_result_a(16'h1234), .conv_result_b(16'h4321),
    .adc_a_chan_select, .adc_b_chan_select, .src_kind_a, .src_kind_b, .result_a, .result_b,
    .range_a_codes, .range_b_codes, .range_in0_a, .range_in1_a, .range_in2_a, .range_in3_a);
  // ****************************************************************
  // clock, tasks and checks
  // ****************************************************************
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; read data and error are taken at the completing edge, then one
  // idle cycle, so a following call never drives psel twice in one time step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    er_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic do_reset();
    presetn <= 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
  endtask
  task automatic chk_rst();
    apb(12'h00C, 0, 0);
    chk("chan reset", 32'h0, rd_q);
    apb(12'h010, 0, 0);
    chk("a1 reset", 32'h00FF, rd_q);
    apb(12'h01C, 0, 0);
    chk("b2 reset", 32'h00FF, rd_q);
    chk("in3 reset", rcr_pkg::RCR_RNG_10V, range_in3_a);
    chk("sel a reset", 32'h0, adc_a_chan_select);
    chk("ready", 32'h1, pready);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    do_reset();
    chk_rst();
    foreach (rows[i]) begin
      apb(rows[i].a, 1, rows[i].d);
      apb(rows[i].a, 0, 0);
      chk("rdata", rows[i].rd, rd_q);
      chk("slverr", rows[i].er, er_q);
    end
    chk("a codes", 16'h5AE4, range_a_codes);
    chk("b codes", 16'hAA55, range_b_codes);
    chk("in3", rcr_pkg::RCR_RNG_10V, range_in3_a);
    chk("in2", rcr_pkg::RCR_RNG_5V, range_in2_a);
    chk("in1", rcr_pkg::RCR_RNG_2V5, range_in1_a);
    chk("src b", rcr_pkg::RCR_SRC_INPUT, src_kind_b);
    for (int c = 0; c < 16; c++) begin
      apb(12'h00C, 1, {24'h0, c[3:0], c[3:0]});
      chk("src a", c < 8 ? rcr_pkg::RCR_SRC_INPUT : c < 10 ? rcr_pkg::RCR_SRC_MON :
          c == 11 ? rcr_pkg::RCR_SRC_TEST : rcr_pkg::RCR_SRC_NONE, src_kind_a);
      chk("res a", c == 11 ? 16'hAAAA : 16'h1234, result_a);
      chk("res b", c == 11 ? 16'h5555 : 16'h4321, result_b);
    end
    // byte strobes: lane 1 alone moves the address field, lane 0 alone the selects
    pstrb <= 4'h2;
    apb(12'h00C, 1, 32'h0000A400);
    pstrb <= 4'h1;
    apb(12'h00C, 1, 32'h00000012);
    pstrb <= 4'hF;
    apb(12'h00C, 0, 0);
    chk("strobes", 32'h0000A412, rd_q);
    chk("sel a", 32'h2, adc_a_chan_select);
    chk("sel b", 32'h1, adc_b_chan_select);
    for (int c = 0; c < 4; c++) begin
      apb(12'h010, 1, {30'h0, c[1:0]});
      chk("in0", c == 1 ? rcr_pkg::RCR_RNG_2V5 : c == 2 ? rcr_pkg::RCR_RNG_5V :
          rcr_pkg::RCR_RNG_10V, range_in0_a);
    end
    do_reset();
    chk_rst();
    close_out();
  end
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule
